// *** core/wave_adjust_pkg.sv ***
// Constants, thresholds and types for lost-frame waveform adjustment
package wave_adjust_pkg;
    localparam int SAMPLE_W = 16;
    localparam int ACC_W = 48;
    localparam int DB_W = 16;
    localparam int Q15_SHIFT = 15;
    localparam int DB_FRAC_SHIFT = 8;
    localparam int DEF_FRAME_LEN = 256;
    localparam int WIN_N = 8;

    // Log energies in dB, Q8
    localparam logic signed [15:0] SILENCE_DB = 16'sh3200;
    localparam logic signed [15:0] LONG_ENERGY_INIT = 16'sh3b6d;
    localparam logic signed [16:0] SILENT_GAP_DB = 17'sh00800;
    localparam logic signed [16:0] DROP_GAP_DB = 17'sh00600;
    localparam logic signed [16:0] RISE_GAP_DB = 17'sh00100;
    localparam logic [15:0] DB_PER_OCTAVE = 16'h0303;

    // Correlation and ratios, Q15
    localparam logic [15:0] CORR_SILENT = 16'h7333;
    localparam logic [15:0] CORR_USABLE = 16'h6666;
    localparam logic [15:0] CORR_RISE = 16'h4ccd;
    localparam logic [15:0] HARM_MIN = 16'h599a;
    localparam logic [15:0] LONG_ENERGY_STEP = 16'h028f;
    localparam logic [15:0] NOISE_GAIN_STEP = 16'h0148;
    localparam logic [15:0] HP_COEF = 16'h570a;
    localparam logic [15:0] GAIN_ONE = 16'h8000;
    localparam logic [15:0] WIN_FULL = 16'h8000;

    localparam logic [15:0] ZCR_MAX = 16'h0064;
    localparam logic [2:0] LOST_ADJ_LAST = 3'h4;
    localparam logic [2:0] LOST_SAT = 3'h5;
    localparam logic [2:0] LOST_FIRST = 3'h1;

    // Fade-in window; fade-out is its complement
    localparam logic [15:0] FADE_IN_TAB [0:WIN_N-1] = '{
        16'h0800, 16'h1800, 16'h2800, 16'h3800,
        16'h4800, 16'h5800, 16'h6800, 16'h7800
    };

    typedef enum logic [1:0] {
        MODE_PASS = 2'b00,
        MODE_XFADE = 2'b01,
        MODE_REPEAT = 2'b10,
        MODE_OLA = 2'b11
    } frame_mode_t;
endpackage

// *** core/log_energy.sv ***
// Frame log energy: 10*log10(sum/L) in Q8 dB
`timescale 1ns/1ps
module log_energy #(
    parameter int FRAME_LEN = wave_adjust_pkg::DEF_FRAME_LEN
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic [wave_adjust_pkg::ACC_W-1:0] i_sum,
    output logic o_valid,
    output logic signed [wave_adjust_pkg::DB_W-1:0] o_db
);
    import wave_adjust_pkg::*;

    // Log2 in Q8: leading-one position plus linear fraction
    function automatic logic [15:0] log2_q8(input logic [ACC_W-1:0] v);
        int p;
        logic [ACC_W-1:0] nrm;
        p = 0;
        for (int b = 0; b < ACC_W; b++) begin
            if (v[b]) begin
                p = b;
            end
        end
        nrm = v << (ACC_W - 1 - p);
        log2_q8 = {p[7:0], nrm[ACC_W-2 -: 8]};
    endfunction

    function automatic logic [15:0] to_db(input logic [15:0] l2);
        logic [31:0] prod;
        prod = l2 * DB_PER_OCTAVE;
        to_db = prod[DB_FRAC_SHIFT +: 16];
    endfunction

    localparam logic [15:0] LEN_DB = to_db(log2_q8(ACC_W'(FRAME_LEN)));

    wire logic [15:0] sum_db = to_db(log2_q8(i_sum));
    wire logic signed [DB_W-1:0] db_nxt = (i_sum == '0) ? -$signed(LEN_DB)
                                         : $signed(sum_db) - $signed(LEN_DB);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_valid <= 1'b0;
            o_db <= '0;
        end else begin
            o_valid <= i_start;
            if (i_start) begin
                o_db <= db_nxt;
            end
        end
    end
endmodule

// *** core/wave_adjust.sv ***
// Time-domain waveform adjustment for non-tonal concealment of lost frames
// Behaviour
// R1: Frame log energy is 10*log10 of mean square of final output samples.
// R2: Long-term energy starts 59.426, blends 0.98/0.02 if energy>50 and zcr<100.
// R3: Pitch unusable if prior energy<50, or corr<0.9 and long-term gap>8.0.
// R4: Criteria checked in order; not silent and corr>0.8 means usable.
// R5: Else unusable when prior frame zero-crossing rate exceeds 100.
// R6: Else unusable when long-term minus prior energy exceeds 6.0.
// R7: Else usable when prior energy exceeds long-term by 1.0 and corr>0.6.
// R8: Else usable only when harmonic energy ratio is at least 0.7.
// R9: Later lost frames reuse pitch and decision from first lost frame.
// R10: Unusable pitch passes the initially compensated signal through.
// R11: From fifth lost frame on, pass initially compensated signal through.
// R12: First lost frame loads quarter-pitch buffer head from compensated input.
// R13: First lost frame repeats last period plus head, cross-faded each copy.
// R14: Lost frames two to four repeat previous output's last period.
// R15: Frames one to three output buffer; fourth overlap-adds with input.
// R16: Add high-pass (0.68) noise from pre-loss or previous input frame.
// R17: Noise gain starts zero, tracks 1-corr/2 with 0.99/0.01 per sample.
// R18: Fourth lost frame adds noise before its overlap-add.
// R19: First good frame after 1-3 losses: repeat, add noise, overlap-add.
// R20: Complementary fade-in/fade-out tables shape cross-fades and overlap-adds.
`timescale 1ns/1ps
module wave_adjust #(
    parameter int FRAME_LEN = wave_adjust_pkg::DEF_FRAME_LEN,
    parameter int IDX_W = $clog2(FRAME_LEN)
) (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    // Frame control and first-loss analysis results
    input wire logic I_FRAME_START,
    input wire logic I_FRAME_LOST,
    input wire logic [IDX_W-1:0] I_PITCH_PERIOD,
    input wire logic [15:0] I_PEAK_CORR,
    input wire logic [15:0] I_HARM_RATIO,
    // Input sample stream
    input wire logic I_IN_VALID,
    input wire logic signed [wave_adjust_pkg::SAMPLE_W-1:0] I_IN_SAMPLE,
    // Output sample stream
    output logic O_OUT_VALID,
    output logic signed [wave_adjust_pkg::SAMPLE_W-1:0] O_OUT_SAMPLE,
    // Status
    output logic O_PITCH_USABLE,
    output logic [2:0] O_LOST_COUNT,
    output logic signed [wave_adjust_pkg::DB_W-1:0] O_FRAME_ENERGY,
    output logic signed [wave_adjust_pkg::DB_W-1:0] O_LONG_ENERGY
);
    import wave_adjust_pkg::*;

    localparam logic [IDX_W:0] LEN_W = (IDX_W+1)'(FRAME_LEN);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(FRAME_LEN - 1);
    localparam logic [3:0] WIN_STEP = 4'(WIN_N);
    localparam logic [2:0] WIN_LAST = 3'(WIN_N - 1);

    // Two banks each: current frame is written, the other holds the prior frame
    logic signed [SAMPLE_W-1:0] in_mem [0:1][0:FRAME_LEN-1];
    logic signed [SAMPLE_W-1:0] out_mem [0:1][0:FRAME_LEN-1];

    logic bank_r;
    frame_mode_t mode_r, mode_nxt;
    logic [2:0] lost_cnt_r, lost_cnt_nxt;
    logic [IDX_W-1:0] pitch_r;
    logic [15:0] corr_r;
    logic usable_r;
    logic [IDX_W-1:0] n_r;
    logic [IDX_W-1:0] j_r;
    logic [2:0] win_idx_r;
    logic [IDX_W:0] win_acc_r;
    logic signed [16:0] gain_r;
    logic [ACC_W-1:0] acc_r;
    logic [15:0] zc_cnt_r;
    logic [15:0] zcr_r;
    logic last_neg_r;
    logic log_start_r;
    logic signed [DB_W-1:0] ener_r;
    logic signed [DB_W-1:0] lt_r;
    logic log_valid;
    logic signed [DB_W-1:0] log_db;

    // Pitch usability, evaluated at the start of the first lost frame
    wire logic signed [16:0] lt_gap = 17'(lt_r) - 17'(ener_r);
    wire logic silent = (ener_r < SILENCE_DB)                              // R3
                        || ((I_PEAK_CORR < CORR_SILENT) && (lt_gap > SILENT_GAP_DB)); // R3
    logic usable_dec;
    always_comb begin
        if (silent) begin
            usable_dec = 1'b0; // R3
        end else if (I_PEAK_CORR > CORR_USABLE) begin
            usable_dec = 1'b1; // R4
        end else if (zcr_r > ZCR_MAX) begin
            usable_dec = 1'b0; // R5
        end else if (lt_gap > DROP_GAP_DB) begin
            usable_dec = 1'b0; // R6
        end else if ((-lt_gap > RISE_GAP_DB) && (I_PEAK_CORR > CORR_RISE)) begin
            usable_dec = 1'b1; // R7
        end else begin
            usable_dec = (I_HARM_RATIO >= HARM_MIN); // R8
        end
    end

    wire logic first_loss = I_FRAME_LOST && (lost_cnt_r == '0);
    wire logic usable_eff = first_loss ? usable_dec : usable_r; // R9
    wire logic recover = !I_FRAME_LOST && usable_r && (lost_cnt_r != '0)
                         && (lost_cnt_r < LOST_ADJ_LAST); // R19
    assign lost_cnt_nxt = !I_FRAME_LOST ? 3'h0
                          : (lost_cnt_r == LOST_SAT) ? LOST_SAT : lost_cnt_r + 3'h1;

    always_comb begin
        if (!I_FRAME_LOST) begin
            mode_nxt = recover ? MODE_OLA : MODE_PASS; // R19
        end else if (!usable_eff || (lost_cnt_nxt > LOST_ADJ_LAST)) begin
            mode_nxt = MODE_PASS; // R10 R11
        end else if (lost_cnt_nxt == LOST_FIRST) begin
            mode_nxt = MODE_XFADE; // R12 R13
        end else if (lost_cnt_nxt == LOST_ADJ_LAST) begin
            mode_nxt = MODE_OLA; // R15
        end else begin
            mode_nxt = MODE_REPEAT; // R14
        end
    end

    // Sample datapath
    wire logic prev_bank = ~bank_r;
    wire logic [IDX_W-1:0] quarter = pitch_r >> 2;
    wire logic [IDX_W:0] rep_idx = LEN_W - {1'b0, pitch_r} + {1'b0, j_r};
    wire logic signed [SAMPLE_W-1:0] rep_s =
        out_mem[prev_bank][rep_idx[IDX_W-1:0]]; // R13 R14 R19
    wire logic signed [SAMPLE_W-1:0] head_s =
        (n_r < quarter) ? I_IN_SAMPLE : in_mem[bank_r][j_r]; // R12
    wire logic [15:0] fade_in = FADE_IN_TAB[win_idx_r]; // R20
    wire logic [15:0] fade_out = WIN_FULL - fade_in; // R20
    wire logic signed [16:0] fi_s = {1'b0, fade_in};
    wire logic signed [16:0] fo_s = {1'b0, fade_out};

    wire logic signed [33:0] xf_mix = 34'(head_s) * 34'(fo_s) + 34'(rep_s) * 34'(fi_s);
    wire logic signed [18:0] xf_s = 19'(xf_mix >>> Q15_SHIFT);
    wire logic in_xfade = (mode_r == MODE_XFADE) && (j_r < quarter);
    wire logic signed [18:0] buf_s = in_xfade ? xf_s : 19'(rep_s); // R13

    // High-pass noise source: pre-loss output on first loss, else prior input
    wire logic [IDX_W-1:0] n_prev = n_r - 1'b1;
    wire logic src_from_out = (mode_r == MODE_XFADE);
    wire logic signed [SAMPLE_W-1:0] src_cur =
        src_from_out ? out_mem[prev_bank][n_r] : in_mem[prev_bank][n_r]; // R16
    wire logic signed [SAMPLE_W-1:0] src_old = (n_r == '0) ? '0
        : src_from_out ? out_mem[prev_bank][n_prev] : in_mem[prev_bank][n_prev];
    wire logic signed [32:0] hp_tap = src_old * $signed({1'b0, HP_COEF});
    wire logic signed [17:0] hp_s = 18'(src_cur) - 18'(hp_tap >>> Q15_SHIFT); // R16

    wire logic signed [16:0] gain_bob = $signed({1'b0, GAIN_ONE}) - 17'(corr_r >> 1); // R17
    wire logic signed [33:0] gain_step = (gain_bob - gain_r) * $signed({1'b0, NOISE_GAIN_STEP});
    wire logic signed [16:0] gain_nxt = gain_r + 17'(gain_step >>> Q15_SHIFT); // R17
    wire logic signed [34:0] noise_prod = hp_s * gain_nxt;
    wire logic signed [19:0] noisy_s = 20'(buf_s) + 20'(noise_prod >>> Q15_SHIFT); // R16 R18

    wire logic signed [SAMPLE_W-1:0] noisy_sat = sat16(36'(noisy_s));
    wire logic signed [35:0] ola_mix = 36'(noisy_sat) * 36'(fo_s) + 36'(I_IN_SAMPLE) * 36'(fi_s);
    wire logic signed [SAMPLE_W-1:0] ola_sat = sat16(ola_mix >>> Q15_SHIFT); // R15 R19

    function automatic logic signed [SAMPLE_W-1:0] sat16(input logic signed [35:0] v);
        if (v > 36'sh00007fff) begin
            sat16 = 16'sh7fff;
        end else if (v < -36'sh000008000) begin
            sat16 = -16'sh8000;
        end else begin
            sat16 = v[SAMPLE_W-1:0];
        end
    endfunction

    logic signed [SAMPLE_W-1:0] final_s;
    always_comb begin
        case (mode_r)
            MODE_PASS: final_s = I_IN_SAMPLE; // R10 R11
            MODE_XFADE: final_s = noisy_sat; // R15
            MODE_REPEAT: final_s = noisy_sat; // R15
            MODE_OLA: final_s = ola_sat; // R15 R18 R19
            default: final_s = I_IN_SAMPLE;
        endcase
    end

    // Window index: ramp over quarter pitch in cross-fades, frame in overlap-add
    wire logic [IDX_W:0] ramp_len = (mode_r == MODE_OLA) ? LEN_W : {1'b0, quarter};
    wire logic [IDX_W:0] win_sum = win_acc_r + (IDX_W+1)'(WIN_STEP);
    wire logic win_adv = (win_sum >= ramp_len);
    wire logic [IDX_W-1:0] j_nxt = (j_r == pitch_r - 1'b1) ? '0 : j_r + 1'b1;
    wire logic win_restart = (mode_r == MODE_XFADE) && (j_nxt == '0); // R13

    // Energy and zero crossings over the final output
    wire logic [31:0] sq = 32'(final_s) * 32'(final_s);
    wire logic [ACC_W-1:0] acc_nxt = acc_r + ACC_W'(sq); // R1
    wire logic crossing = (n_r != '0) && (final_s[SAMPLE_W-1] != last_neg_r);
    wire logic [15:0] zc_nxt = zc_cnt_r + 16'(crossing);
    wire logic last_sample = I_IN_VALID && (n_r == LAST_IDX);
    wire logic signed [16:0] lt_diff = 17'(log_db) - 17'(lt_r);
    wire logic signed [33:0] lt_prod = lt_diff * $signed({1'b0, LONG_ENERGY_STEP});
    wire logic lt_update = log_valid && (log_db > SILENCE_DB) && (zcr_r < ZCR_MAX); // R2

    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            bank_r <= 1'b0;
            mode_r <= MODE_PASS;
            lost_cnt_r <= '0;
            pitch_r <= '0;
            corr_r <= '0;
            usable_r <= 1'b0;
        end else if (I_FRAME_START) begin
            bank_r <= ~bank_r;
            mode_r <= mode_nxt;
            lost_cnt_r <= lost_cnt_nxt;
            usable_r <= usable_eff;
            if (first_loss) begin
                pitch_r <= I_PITCH_PERIOD; // R9
                corr_r <= I_PEAK_CORR; // R9
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            n_r <= '0;
            j_r <= '0;
            win_idx_r <= '0;
            win_acc_r <= '0;
            gain_r <= '0;
        end else if (I_FRAME_START) begin
            n_r <= '0;
            j_r <= '0;
            win_idx_r <= '0;
            win_acc_r <= '0;
            if (first_loss) begin
                gain_r <= '0; // R17
            end
        end else if (I_IN_VALID && (n_r <= LAST_IDX)) begin
            n_r <= n_r + 1'b1;
            j_r <= j_nxt;
            if (win_restart) begin
                win_idx_r <= '0;
                win_acc_r <= '0;
            end else if (win_adv) begin
                win_idx_r <= (win_idx_r == WIN_LAST) ? WIN_LAST : win_idx_r + 3'h1;
                win_acc_r <= win_sum - ramp_len;
            end else begin
                win_acc_r <= win_sum;
            end
            if (mode_r != MODE_PASS) begin
                gain_r <= gain_nxt; // R17
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_IN_VALID) begin
            in_mem[bank_r][n_r] <= I_IN_SAMPLE;
            out_mem[bank_r][n_r] <= final_s;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            acc_r <= '0;
            zc_cnt_r <= '0;
            zcr_r <= '0;
            last_neg_r <= 1'b0;
            log_start_r <= 1'b0;
        end else begin
            log_start_r <= last_sample;
            if (I_FRAME_START) begin
                acc_r <= '0;
                zc_cnt_r <= '0;
            end else if (I_IN_VALID) begin
                acc_r <= acc_nxt; // R1
                zc_cnt_r <= zc_nxt;
                last_neg_r <= final_s[SAMPLE_W-1];
                if (n_r == LAST_IDX) begin
                    zcr_r <= zc_nxt; // R5
                end
            end
        end
    end

    log_energy #(
        .FRAME_LEN(FRAME_LEN)
    ) u_log_energy (
        .i_clock(I_CLOCK),
        .i_sys_rst(I_SYS_RST),
        .i_start(log_start_r),
        .i_sum(acc_r),
        .o_valid(log_valid),
        .o_db(log_db)
    );

    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            ener_r <= '0;
            lt_r <= LONG_ENERGY_INIT; // R2
        end else if (log_valid) begin
            ener_r <= log_db; // R1
            if (lt_update) begin
                lt_r <= lt_r + DB_W'(lt_prod >>> Q15_SHIFT); // R2
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            O_OUT_VALID <= 1'b0;
            O_OUT_SAMPLE <= '0;
            O_PITCH_USABLE <= 1'b0;
            O_LOST_COUNT <= '0;
            O_FRAME_ENERGY <= '0;
            O_LONG_ENERGY <= LONG_ENERGY_INIT;
        end else begin
            O_OUT_VALID <= I_IN_VALID;
            if (I_IN_VALID) begin
                O_OUT_SAMPLE <= final_s;
            end
            O_PITCH_USABLE <= usable_r;
            O_LOST_COUNT <= lost_cnt_r;
            O_FRAME_ENERGY <= ener_r;
            O_LONG_ENERGY <= lt_r;
        end
    end
endmodule

// *** verification/wave_adjust_properties.sv ***
// Port-level checker for the lost-frame waveform adjuster
`timescale 1ns/1ps
module wave_adjust_properties
    import wave_adjust_pkg::*;
#(
    parameter int FRAME_LEN = wave_adjust_pkg::DEF_FRAME_LEN,
    parameter int IDX_W = $clog2(FRAME_LEN)
) (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    // Watched inputs
    input wire logic I_FRAME_START,
    input wire logic I_FRAME_LOST,
    input wire logic [IDX_W-1:0] I_PITCH_PERIOD,
    input wire logic [15:0] I_PEAK_CORR,
    input wire logic [15:0] I_HARM_RATIO,
    input wire logic I_IN_VALID,
    input wire logic signed [wave_adjust_pkg::SAMPLE_W-1:0] I_IN_SAMPLE,
    // Watched outputs
    input wire logic O_OUT_VALID,
    input wire logic signed [wave_adjust_pkg::SAMPLE_W-1:0] O_OUT_SAMPLE,
    input wire logic O_PITCH_USABLE,
    input wire logic [2:0] O_LOST_COUNT,
    input wire logic signed [wave_adjust_pkg::DB_W-1:0] O_FRAME_ENERGY,
    input wire logic signed [wave_adjust_pkg::DB_W-1:0] O_LONG_ENERGY
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST);

    property p_energy_slot;
        $changed(O_FRAME_ENERGY) |-> $past(O_OUT_VALID, 3) && !$past(O_OUT_VALID, 2);
    endproperty
    a_energy_slot: assert property (p_energy_slot)
        else $error("frame energy moved outside its slot");

    property p_long_init;
        $fell(I_SYS_RST) |-> O_LONG_ENERGY == LONG_ENERGY_INIT && O_LOST_COUNT == 3'h0;
    endproperty
    a_long_init: assert property (p_long_init)
        else $error("long energy not at start value");

    property p_long_gate;
        $changed(O_LONG_ENERGY) |-> O_FRAME_ENERGY > SILENCE_DB;
    endproperty
    a_long_gate: assert property (p_long_gate)
        else $error("long energy moved on a quiet frame");

    property p_silent_loss;
        O_LOST_COUNT == LOST_FIRST && $past(O_LOST_COUNT) == 3'h0
            && O_FRAME_ENERGY < SILENCE_DB |-> !O_PITCH_USABLE;
    endproperty
    a_silent_loss: assert property (p_silent_loss)
        else $error("pitch usable after quiet frame");

    property p_voiced_loss;
        O_LOST_COUNT == LOST_FIRST && $past(O_LOST_COUNT) == 3'h0
            && !(O_FRAME_ENERGY < SILENCE_DB) && $past(I_PEAK_CORR, 2) >= CORR_SILENT
            |-> O_PITCH_USABLE;
    endproperty
    a_voiced_loss: assert property (p_voiced_loss)
        else $error("pitch unusable on strong voiced frame");

    property p_reuse;
        O_LOST_COUNT > LOST_FIRST |-> $stable(O_PITCH_USABLE);
    endproperty
    a_reuse: assert property (p_reuse)
        else $error("decision changed within a loss run");

    property p_unusable_pass;
        O_OUT_VALID && O_LOST_COUNT != 3'h0 && !O_PITCH_USABLE
            |-> O_OUT_SAMPLE == $past(I_IN_SAMPLE);
    endproperty
    a_unusable_pass: assert property (p_unusable_pass)
        else $error("unusable pitch did not pass input");

    property p_late_pass;
        O_OUT_VALID && O_LOST_COUNT == LOST_SAT |-> O_OUT_SAMPLE == $past(I_IN_SAMPLE);
    endproperty
    a_late_pass: assert property (p_late_pass)
        else $error("late loss did not pass input");

    property p_count_step;
        $changed(O_LOST_COUNT) |-> O_LOST_COUNT <= LOST_SAT
            && (O_LOST_COUNT == 3'h0 || O_LOST_COUNT == $past(O_LOST_COUNT) + 3'h1);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("lost count stepped wrongly");
endmodule

bind wave_adjust wave_adjust_properties #(.FRAME_LEN(FRAME_LEN), .IDX_W(IDX_W)) u_props (
    .I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_FRAME_START(I_FRAME_START),
    .I_FRAME_LOST(I_FRAME_LOST), .I_PITCH_PERIOD(I_PITCH_PERIOD),
    .I_PEAK_CORR(I_PEAK_CORR), .I_HARM_RATIO(I_HARM_RATIO), .I_IN_VALID(I_IN_VALID),
    .I_IN_SAMPLE(I_IN_SAMPLE), .O_OUT_VALID(O_OUT_VALID), .O_OUT_SAMPLE(O_OUT_SAMPLE),
    .O_PITCH_USABLE(O_PITCH_USABLE), .O_LOST_COUNT(O_LOST_COUNT),
    .O_FRAME_ENERGY(O_FRAME_ENERGY), .O_LONG_ENERGY(O_LONG_ENERGY)
);

// *** verification/frame_feeder.sv ***
// Upstream decoder model: frame strobes, analysis values, sample stream
`timescale 1ns/1ps
module frame_feeder #(
    parameter int IDX_W = 5,
    parameter int FRAME_LEN = 32
) (
    // Clock
    input wire logic i_clock,
    // Frame request
    input wire logic i_go,
    input wire logic i_lost,
    input wire logic i_slow,
    input wire logic [15:0] i_amp,
    input wire logic [15:0] i_corr,
    input wire logic [15:0] i_harm,
    input wire logic [IDX_W-1:0] i_pitch,
    // Toward the adjuster, plus o_done back to the bench
    output logic o_frame_start,
    output logic o_frame_lost,
    output logic [IDX_W-1:0] o_pitch,
    output logic [15:0] o_corr,
    output logic [15:0] o_harm,
    output logic o_in_valid,
    output logic signed [15:0] o_in_sample,
    output logic o_done
);
    task automatic send_frame();
        int n;
        o_done = 1'b0;
        o_frame_lost = i_lost;
        o_pitch = i_pitch;
        o_corr = i_corr;
        o_harm = i_harm;
        o_frame_start = 1'b1;
        @(negedge i_clock);
        o_frame_start = 1'b0;
        repeat (3) @(negedge i_clock);
        for (n = 0; n < FRAME_LEN; n++) begin
            o_in_sample = (n[3] ^ (i_lost & n[2])) ? -i_amp : i_amp;
            o_in_valid = 1'b1;
            @(negedge i_clock);
            if (i_slow && n % 3 == 2) begin
                // Idle cycle, bus carries junk
                o_in_valid = 1'b0;
                o_in_sample = ~o_in_sample;
                @(negedge i_clock);
            end
        end
        o_in_valid = 1'b0;
        o_in_sample = ~o_in_sample;
        // Energy bookkeeping settles before next start
        repeat (6) @(negedge i_clock);
        o_done = 1'b1;
    endtask

    initial begin
        o_frame_start = 1'b0;
        o_frame_lost = 1'b0;
        o_pitch = '0;
        o_corr = 16'h0000;
        o_harm = 16'h0000;
        o_in_valid = 1'b0;
        o_in_sample = 16'sh0000;
        o_done = 1'b0;
        forever begin
            @(posedge i_clock);
            if (i_go === 1'b1) begin
                @(negedge i_clock);
                send_frame();
            end
        end
    end
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the lost-frame waveform adjuster
`timescale 1ns/1ps
module tb_top;
    import wave_adjust_pkg::*;
    localparam int FL = 32;
    localparam int IW = 5;
    typedef struct {
        logic [15:0] amp;
        logic [15:0] corr;
        logic [15:0] harm;
        logic [2:0] cnt;
        logic use_ok;
        logic pass;
    } row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic lost = 1'b0;
    logic slow = 1'b0;
    logic [15:0] amp = 16'h0000;
    logic [15:0] corr = 16'h0000;
    logic [15:0] harm = 16'h0000;
    logic start, lost_q, in_valid, out_valid, usable, done;
    logic [IW-1:0] pitch;
    logic [15:0] corr_q, harm_q;
    logic signed [15:0] in_sample, out_sample, frame_energy, long_energy;
    logic [2:0] lost_count;
    logic signed [15:0] in_q[$], out_q[$];
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    row_t rows [19] = '{
        '{16'h0008, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b1},
        '{16'h0008, 16'h7fff, 16'h7fff, 3'h1, 1'b0, 1'b1},
        '{16'h0008, 16'h7fff, 16'h7fff, 3'h2, 1'b0, 1'b1},
        '{16'h0400, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b1},
        '{16'h0400, 16'h7333, 16'h0000, 3'h1, 1'b1, 1'b0},
        '{16'h0400, 16'h0000, 16'h0000, 3'h2, 1'b1, 1'b0},
        '{16'h0400, 16'h0000, 16'h0000, 3'h3, 1'b1, 1'b0},
        '{16'h0400, 16'h0000, 16'h0000, 3'h4, 1'b1, 1'b0},
        '{16'h0400, 16'h0000, 16'h0000, 3'h5, 1'b1, 1'b1},
        '{16'h0190, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b1},
        '{16'h0190, 16'h5999, 16'h0000, 3'h1, 1'b0, 1'b1},
        '{16'h0800, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b1},
        '{16'h0800, 16'h5999, 16'h0000, 3'h1, 1'b1, 1'b0},
        '{16'h0800, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b0},
        '{16'h0800, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b1},
        '{16'h0800, 16'h4000, 16'h599a, 3'h1, 1'b1, 1'b0},
        '{16'h0800, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b0},
        '{16'h0800, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b1},
        '{16'h0800, 16'h4000, 16'h5999, 3'h1, 1'b0, 1'b1}
    };

    always #10 clk = ~clk;

    frame_feeder #(.IDX_W(IW), .FRAME_LEN(FL)) u_feed (
        .i_clock(clk), .i_go(go), .i_lost(lost), .i_slow(slow), .i_amp(amp),
        .i_corr(corr), .i_harm(harm), .i_pitch(5'h10), .o_frame_start(start),
        .o_frame_lost(lost_q), .o_pitch(pitch), .o_corr(corr_q), .o_harm(harm_q),
        .o_in_valid(in_valid), .o_in_sample(in_sample), .o_done(done)
    );

    wave_adjust #(.FRAME_LEN(FL)) u_dut (
        .I_CLOCK(clk), .I_SYS_RST(rst), .I_FRAME_START(start), .I_FRAME_LOST(lost_q),
        .I_PITCH_PERIOD(pitch), .I_PEAK_CORR(corr_q), .I_HARM_RATIO(harm_q),
        .I_IN_VALID(in_valid), .I_IN_SAMPLE(in_sample), .O_OUT_VALID(out_valid),
        .O_OUT_SAMPLE(out_sample), .O_PITCH_USABLE(usable), .O_LOST_COUNT(lost_count),
        .O_FRAME_ENERGY(frame_energy), .O_LONG_ENERGY(long_energy)
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (in_valid === 1'b1) in_q.push_back(in_sample);
        if (out_valid === 1'b1) out_q.push_back(out_sample);
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end

    task automatic run_frame(input row_t r, input logic sl);
        int k;
        logic diff;
        in_q.delete();
        out_q.delete();
        lost = (r.cnt != 3'h0);
        amp = r.amp;
        corr = r.corr;
        harm = r.harm;
        slow = sl;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        repeat (2) @(negedge clk);
        for (k = 0; k < 400 && done !== 1'b1; k++) @(negedge clk);
        diff = 1'b0;
        check(lost_count, r.cnt);
        if (lost) check(usable, r.use_ok);
        check(out_q.size(), FL);
        for (k = 0; k < FL; k++) begin
            if (r.pass) check(out_q[k], in_q[k]);
            else diff |= out_q[k] !== in_q[k];
        end
        if (!r.pass) check(diff, 1'b1);
    endtask

    initial begin
        repeat (20) @(negedge clk);
        check(long_energy, LONG_ENERGY_INIT);
        rst = 1'b0;
        for (int i = 0; i < 19; i++) begin
            run_frame(rows[i], i[0]);
            if (i == 0) check(frame_energy > 16'sh11ff && frame_energy < 16'sh1220, 1'b1);
            if (i == 0) check(long_energy, LONG_ENERGY_INIT);
            if (i == 3) check(frame_energy > 16'sh3c25 && frame_energy < 16'sh3c45, 1'b1);
            if (i == 3) check(long_energy > LONG_ENERGY_INIT && long_energy < 16'sh3b78, 1'b1);
            $display("frame %0d done", i);
        end
        // Reset in the middle of a loss frame
        lost = 1'b1;
        corr = 16'h7333;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        repeat (12) @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        check(lost_count, 3'h0);
        check(usable, 1'b0);
        check(long_energy, LONG_ENERGY_INIT);
        for (int k = 0; k < 200 && done !== 1'b1; k++) @(negedge clk);
        rst = 1'b0;
        run_frame(rows[0], 1'b0);
        run_frame(rows[1], 1'b1);
        $display("mid-run reset done");
        conclude();
    end
endmodule
